/* File: core/clkrst_top.sv */
`timescale 1ns/1ns
module clkrst_top
   import clkrst_pkg::*;
#(
   parameter int NOUT = NUM_OUT,
   parameter int GW   = GRP_W
)(
   input  wire logic                      CLK,
   input  wire logic                      RST_N,
   input  wire logic                      CE,
   input  wire logic [CNT_W-1:0]          HI_CNT,
   input  wire logic [CNT_W-1:0]          LO_CNT,
   input  wire logic                      HALF_EN,
   input  wire logic                      BYPASS,
   input  wire logic [NUM_PHASE-1:0]      PHASES,
   input  wire logic [NOUT*PH_W-1:0]      PHASE_SEL,
   input  wire logic [NOUT-1:0]           PHASE_STEP,
   input  wire logic [NOUT-1:0]           GATE_ON,
   input  wire logic [NOUT-1:0]           FAB_CLKEN,
   input  wire logic [PAD_W-1:0]          PAD_SEL,
   output      logic [NUM_PAD-1:0]        PAD_OUT,
   output      logic [NOUT-1:0]           GEN_OUT,
   input  wire logic [3:0]                RST_SRC_N,
   input  wire logic [1:0]                RST_SRC_SEL,
   input  wire logic                      RST_SRC_SYNC,
   output      logic                      SYNC_RST_N,
   input  wire logic [LAT_W-1:0]          TAP_LAT,
   input  wire logic [GW-1:0]             GRP_N_IN_N,
   input  wire logic [GW-1:0]             GRP_S_IN_N,
   output      logic [GW-1:0]             GRP_N_OUT_N,
   output      logic [GW-1:0]             GRP_S_OUT_N,
   input  wire logic [RSEL_W-1:0]         BANK_RSEL,
   output      logic                      BANK_RST_N,
   input  wire logic                      PRESET_IN,
   output      logic                      PRESET_Q,
   output      logic                      CLEAR_Q
);
   import clkrst_pkg::*;

   // ----------------------------------------
   // output synthesizer
   // ----------------------------------------
   synth_if s_if ();
   assign s_if.hi_cnt  = HI_CNT;
   assign s_if.lo_cnt  = LO_CNT;
   assign s_if.half_en = HALF_EN;
   assign s_if.bypass  = BYPASS;

   out_synth u_synth (
      .CLK   (CLK),
      .RST_N (RST_N),
      .CE    (CE),
      .s     (s_if.syn)
   );

   // ----------------------------------------
   // phase select, stepping and gating
   // ----------------------------------------
   logic [PH_W-1:0] phase [NOUT];
   logic [NOUT-1:0] step_d;
   logic [NOUT-1:0] en_s1;
   logic [NOUT-1:0] en_s2;
   logic [NOUT-1:0] gen_q;

   for (genvar i = 0; i < NOUT; i++) begin : g_out
      // step advances on a rising request; static select loads while the request is low
      always_ff @(posedge CLK or negedge RST_N) begin
         if (!RST_N) begin
            phase[i]  <= PH_ZERO;
            step_d[i] <= 1'b0;
         end else if (CE) begin
            step_d[i] <= PHASE_STEP[i];
            if (PHASE_STEP[i] && !step_d[i])
               phase[i] <= phase[i] + PH_ONE;
            else if (!PHASE_STEP[i])
               phase[i] <= PHASE_SEL[i*PH_W +: PH_W];
         end
      end

      // enable resynchronised, only changes the gate at period end
      always_ff @(posedge CLK or negedge RST_N) begin
         if (!RST_N) begin
            en_s1[i] <= 1'b0;
            en_s2[i] <= 1'b0;
         end else if (CE) begin
            en_s1[i] <= FAB_CLKEN[i];
            if (s_if.period_end)
               en_s2[i] <= en_s1[i];
         end
      end

      // registered output keeps a fixed one-cycle offset from the input
      always_ff @(posedge CLK or negedge RST_N) begin
         if (!RST_N) gen_q[i] <= 1'b0;
         else if (CE)
            gen_q[i] <= s_if.clk_out && PHASES[phase[i]]
                        && (!GATE_ON[i] || en_s2[i]);
      end

      a_gate_block: assert property (@(posedge CLK) disable iff (!RST_N)
         CE && GATE_ON[i] && !en_s2[i] |=> !gen_q[i])
         else $error("gated output passed while disabled");
   end

   assign GEN_OUT = gen_q;

   // ----------------------------------------
   // pad routing of output 0
   // ----------------------------------------
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) PAD_OUT <= '0;
      else if (CE) begin
         PAD_OUT <= '0;
         if (PAD_SEL < PAD_W'(NUM_PAD))
            PAD_OUT[PAD_SEL] <= gen_q[0];
      end
   end

   a_pad_route: assert property (@(posedge CLK) disable iff (!RST_N)
      CE && PAD_SEL < PAD_W'(NUM_PAD) |=> $countones(PAD_OUT) <= 1)
      else $error("more than one pad driven");

   // ----------------------------------------
   // reset input block and synchronizer
   // ----------------------------------------
   // sources are assumed active low and glitch free
   logic             src_n;
   logic             rs1_n;
   logic             rs2_n;
   assign src_n = RST_SRC_N[RST_SRC_SEL];

   // async source: assert at once, release through two flops
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rs1_n <= 1'b0;
         rs2_n <= 1'b0;
      end else if (CE) begin
         rs1_n <= src_n;
         rs2_n <= rs1_n;
      end
   end

   // a source already in this domain skips the release delay
   assign SYNC_RST_N = RST_SRC_SYNC ? src_n : (rs2_n && src_n);

   a_release_sync: assert property (@(posedge CLK) disable iff (!RST_N)
      CE && !RST_SRC_SYNC && $rose(rs2_n) |-> $past(src_n, 2))
      else $error("reset released without synchronizer delay");

   // ----------------------------------------
   // global reset groups with tap latency
   // ----------------------------------------
   localparam int NSTG = 4;
   logic [GW-1:0] pn [NSTG];
   logic [GW-1:0] ps [NSTG];

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         for (int k = 0; k < NSTG; k++) begin
            pn[k] <= '0;
            ps[k] <= '0;
         end
      end else if (CE) begin
         pn[0] <= GRP_N_IN_N;
         ps[0] <= GRP_S_IN_N;
         for (int k = 1; k < NSTG; k++) begin
            pn[k] <= pn[k-1];
            ps[k] <= ps[k-1];
         end
      end
   end

   assign GRP_N_OUT_N = pn[TAP_LAT];
   assign GRP_S_OUT_N = ps[TAP_LAT];

   // ----------------------------------------
   // bank reset network
   // ----------------------------------------
   logic [BANK_W-1:0] bank1;
   logic [BANK_W-1:0] bank2;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         bank1 <= '0;
         bank2 <= '0;
      end else if (CE) begin
         bank1 <= {GRP_S_OUT_N, GRP_N_OUT_N};
         bank2 <= bank1;
      end
   end

   assign BANK_RST_N = bank2[BANK_RSEL];

   a_bank_lat: assert property (@(posedge CLK) disable iff (!RST_N)
      CE ##1 CE |-> bank2 == $past({GRP_S_OUT_N, GRP_N_OUT_N}, 2))
      else $error("bank reset latency not two stages");

   // ----------------------------------------
   // post-configuration initial values
   // ----------------------------------------
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) PRESET_Q <= 1'b1;
      else if (CE) PRESET_Q <= PRESET_IN;
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) CLEAR_Q <= 1'b0;
      else if (CE) CLEAR_Q <= PRESET_IN;
   end

   a_init_follow: assert property (@(posedge CLK) disable iff (!RST_N)
      CE |=> PRESET_Q == $past(PRESET_IN) && CLEAR_Q == $past(PRESET_IN))
      else $error("initialised flop did not follow its data");
endmodule : clkrst_top

/* File: core/clkrst_pkg.sv */
// Contract
// - divide input by 1 to 2046, 1 bypasses
// - two independent 10-bit high and low counts
// - divisor equals high plus low counts
// - half-cycle option extends high phase
// - each of four outputs picks any phase
// - outputs can step through phases sequentially
// - clock enable synchronized to synthesizer output
// - gating switchable per output
// - gated output aligned with synthesizer input
// - one output routable to any pad buffer
// - distributed resets are active low
// - async reset synchronized on release per domain
// - sync reset used directly in own domain
// - each reset synchronized by selected clock domain
// - input multiplexer picks reset source per synchronizer
// - reset pipelined for balanced latency
// - two opposite groups of eight resets
// - tap pipeline mux with configurable latency
// - bank gets 16 lines, pick clock's reset
// - two pipeline stages across each bank
// - preset flops start one, others zero
package clkrst_pkg;
   localparam int CNT_W      = 10;
   localparam int NUM_OUT    = 4;
   localparam int NUM_PHASE  = 8;
   localparam int PH_W       = 3;
   localparam int NUM_PAD    = 6;
   localparam int PAD_W      = 3;
   localparam int GRP_W      = 8;
   localparam int BANK_W     = 16;
   localparam int RSEL_W     = 4;
   localparam int LAT_W      = 2;
   localparam int SYNC_DEPTH = 2;
   localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
   localparam logic [PH_W-1:0]  PH_ZERO = 3'h0;
   localparam logic [PH_W-1:0]  PH_ONE  = 3'h1;
endpackage : clkrst_pkg

/* File: core/synth_if.sv */
`timescale 1ns/1ns
interface synth_if;
   import clkrst_pkg::*;
   logic [CNT_W-1:0] hi_cnt;
   logic [CNT_W-1:0] lo_cnt;
   logic             half_en;
   logic             bypass;
   logic             clk_out;
   logic             period_end;
   modport ctl (output hi_cnt, lo_cnt, half_en, bypass, input clk_out, period_end);
   modport syn (input hi_cnt, lo_cnt, half_en, bypass, output clk_out, period_end);
endinterface : synth_if

/* File: core/out_synth.sv */
`timescale 1ns/1ns
// output synthesizer on a 2x-rate enable model: each CLK is a half input cycle
module out_synth
   import clkrst_pkg::*;
(
   input  wire logic CLK,
   input  wire logic RST_N,
   input  wire logic CE,
   synth_if.syn      s
);
   logic [CNT_W:0] hcnt;
   logic           phase_hi;
   logic           tog;
   logic [CNT_W-1:0] hi_q;
   logic [CNT_W-1:0] lo_q;
   logic             half_q;
   logic             div_out;
   logic             last;

   // settings taken only at a period boundary
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         hi_q   <= CNT_ONE;
         lo_q   <= CNT_ONE;
         half_q <= 1'b0;
      end else if (CE && last) begin
         hi_q   <= s.hi_cnt;
         lo_q   <= s.lo_cnt;
         half_q <= s.half_en;
      end
   end

   // count half cycles: high phase = 2*hi (+1 when half), low = 2*lo
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         hcnt     <= '0;
         phase_hi <= 1'b1;
      end else if (CE) begin
         if (phase_hi && (hcnt + 1'b1 >= {hi_q, half_q})) begin
            phase_hi <= 1'b0;
            hcnt     <= '0;
         end else if (!phase_hi && (hcnt + 1'b1 >= {lo_q, 1'b0})) begin
            phase_hi <= 1'b1;
            hcnt     <= '0;
         end else begin
            hcnt <= hcnt + 1'b1;
         end
      end
   end

   assign last = !phase_hi && (hcnt + 1'b1 >= {lo_q, 1'b0});

   // half-rate toggle stands for the undivided input clock in bypass
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) tog <= 1'b0;
      else if (CE) tog <= ~tog;
   end

   assign div_out      = phase_hi;
   assign s.clk_out    = s.bypass ? tog : div_out;
   assign s.period_end = s.bypass ? 1'b1 : last;

   a_period_sum: assert property (@(posedge CLK) disable iff (!RST_N)
      CE && $fell(phase_hi) |-> hi_q != CNT_ZERO || half_q)
      else $error("high phase ended with empty count");
endmodule : out_synth

/* File: tb/fabric_model.sv */
`timescale 1ns/1ns
module fabric_model (
   input  wire logic       CLK,
   input  wire logic [3:0] en_req,
   input  wire logic [3:0] rst_req_n,
   output      logic [3:0] clken,
   output      logic [3:0] rst_src_n
);
   // ---------------------------------------------
   // fabric side: flopped, so no glitch escapes
   // ---------------------------------------------
   initial begin
      clken     = 4'hf;
      rst_src_n = 4'hf;
   end
   always @(posedge CLK) begin
      clken     <= en_req;
      rst_src_n <= rst_req_n;
   end
endmodule : fabric_model

/* File: tb/clock_divider_gate_reset_sync_test.sv */
`timescale 1ns/1ns
module clock_divider_gate_reset_sync_test;
   import clkrst_pkg::*;
   typedef struct {int when; int sel; logic [15:0] exp;} note_s;
   note_s            notes[$];
   note_s            n;
   logic             CLK = 1'b0;
   logic             RST_N = 1'b0;
   logic [CNT_W-1:0] hi = CNT_ONE;
   logic [CNT_W-1:0] lo = CNT_ONE;
   logic             half = 1'b0, byp = 1'b0, psync = 1'b0, pin = 1'b0;
   logic [7:0]       phases = 8'hff, gni = 8'h00, gsi = 8'h00, gno, gso;
   logic [11:0]      psel = 12'h000;
   logic [3:0]       pstep = 4'h0, gate = 4'h0, en_req = 4'hf, rst_req_n = 4'hf;
   logic [3:0]       clken, rsrc_n, gen, rsel = 4'h0;
   logic [2:0]       padsel = 3'h0;
   logic [1:0]       ssel = 2'h0, tlat = 2'h0;
   logic [5:0]       pad;
   logic             srst, bank, pq, cq;
   logic [15:0]      gsh = 16'h0000;
   logic [23:0]      psh = 24'h000000;
   logic [31:0]      seed = 32'h00000031, old;
   int               cyc = 0, failures = 0, checked = 0, w;
   int               hrun = 0, lrun = 0, lhi = 0, llo = 0, prev = 0;
   logic             ce = 1'b1;
   int               hv[5] = '{1, 2, 3, 1023, 1};
   int               lv[5] = '{1, 3, 2, 1023, 1};
   int               hf[5] = '{0, 1, 0, 0, 0};

   always #4 CLK = ~CLK;

   fabric_model fab_u (.CLK(CLK), .en_req(en_req), .rst_req_n(rst_req_n), .clken(clken),
                       .rst_src_n(rsrc_n));
   clkrst_top dut_u (
      .CLK(CLK), .RST_N(RST_N), .CE(ce), .HI_CNT(hi), .LO_CNT(lo), .HALF_EN(half),
      .BYPASS(byp), .PHASES(phases), .PHASE_SEL(psel), .PHASE_STEP(pstep), .GATE_ON(gate),
      .FAB_CLKEN(clken), .PAD_SEL(padsel), .PAD_OUT(pad), .GEN_OUT(gen), .RST_SRC_N(rsrc_n),
      .RST_SRC_SEL(ssel), .RST_SRC_SYNC(psync), .SYNC_RST_N(srst), .TAP_LAT(tlat),
      .GRP_N_IN_N(gni), .GRP_S_IN_N(gsi), .GRP_N_OUT_N(gno), .GRP_S_OUT_N(gso),
      .BANK_RSEL(rsel), .BANK_RST_N(bank), .PRESET_IN(pin), .PRESET_Q(pq), .CLEAR_Q(cq));

   // ---------------------------------------------
   // monitor: sampled 2 ns after the falling edge
   // ---------------------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic logic [15:0] obs(int s);
      case (s)
         0: return {gso, gno};
         1: return {15'h0000, bank};
         2: return {15'h0000, srst};
         3: return {14'h0000, pq, cq};
         4: return lhi[15:0];
         5: return llo[15:0];
         6: return {12'h000, gsh[15:12] | gsh[11:8] | gsh[7:4] | gsh[3:0]};
         default: return {10'h000, psh[23:18] | psh[17:12] | psh[11:6] | psh[5:0]};
      endcase
   endfunction : obs
   task automatic check(logic [15:0] seen, logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h, want %h", $time, seen, exp);
      end
   endtask : check
   task automatic note(int sel, logic [15:0] exp, int k);
      notes.push_back('{cyc + k, sel, exp});
   endtask : note
   task automatic step(int k);
      repeat (k) @(negedge CLK);
   endtask : step
   task automatic test_done();
      if (failures == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : test_done

   always @(posedge CLK) cyc <= cyc + 1;
   always @(negedge CLK) begin
      #2;
      gsh = {gsh[11:0], gen};
      psh = {psh[17:0], pad};
      if (gen[0] === 1'b1) begin
         hrun++;
         if (lrun > 0) llo = lrun;
         lrun = 0;
      end else begin
         lrun++;
         if (hrun > 0) lhi = hrun;
         hrun = 0;
      end
      while (notes.size() > 0 && notes[0].when <= cyc) begin
         n = notes.pop_front();
         check(obs(n.sel), n.exp);
      end
   end

   // ---------------------------------------------
   // stimulus, one 125 MHz cycle per half input cycle
   // ---------------------------------------------
   initial begin
      fork
         begin #(8 * 30000); failures++; test_done(); end
      join_none
      note(3, 16'h0002, 1);
      note(0, 16'h0000, 1);
      note(2, 16'h0000, 1);
      step(2);
      RST_N = 1'b1;
      note(3, 16'h0000, 1);
      step(1);
      pin = 1'b1;
      note(3, 16'h0003, 1);
      for (int t = 0; t < 4; t++) begin
         old = xs();
         {gsi, gni} = old[15:0];
         tlat = 2'(t);
         rsel = old[19:16];
         step(6);
         {gsi, gni} = ~old[15:0];
         note(0, old[15:0], t);
         note(0, ~old[15:0], t + 1);
         note(1, {15'h0000, old[rsel]}, t + 2);
         note(1, {15'h0000, ~old[rsel]}, t + 3);
         step(8);
      end
      step(8);
      for (int s = 0; s < 4; s++) begin
         ssel = 2'(s);
         rst_req_n = ~(4'h1 << s);
         note(2, 16'h0000, 1);
         step(4);
         rst_req_n = 4'hf;
         note(2, 16'h0000, 2);
         note(2, 16'h0001, 3);
         step(4);
      end
      {psync, ssel, rst_req_n} = {1'b1, 2'h0, 4'he};
      note(2, 16'h0000, 4);
      step(5);
      rst_req_n = 4'hf;
      note(2, 16'h0001, 4);
      step(5);
      psync = 1'b0;
      for (int i = 0; i < 5; i++) begin
         hi = CNT_W'(hv[i]);
         lo = CNT_W'(lv[i]);
         half = hf[i][0];
         byp = (i == 0);
         // a new setting waits for the old period to finish
         w = 3 * (2 * (hv[i] + lv[i]) + 1) + 8 + prev;
         note(4, byp ? 16'h0001 : 16'(2 * hv[i] + hf[i]), w);
         note(5, byp ? 16'h0001 : 16'(2 * lv[i]), w);
         step(w + 1);
         prev = 2 * (hv[i] + lv[i]) + 1;
      end
      {phases, psel} = {8'h0f, 3'h7, 3'h4, 3'h3, 3'h0};
      step(10);
      note(6, 16'h0003, 0);
      {phases, psel, gate, en_req} = {8'hff, 12'h000, 4'h5, 4'h1};
      step(10);
      note(6, 16'h000b, 0);
      {phases, gate} = {8'h02, 4'h0};
      step(10);
      note(6, 16'h0000, 0);
      pstep = 4'h1;
      step(10);
      note(6, 16'h0001, 0);
      pstep = 4'h0;
      phases = 8'hff;
      for (int s = 0; s < 8; s++) begin
         padsel = 3'(s);
         step(8);
         note(7, (s < 6) ? 16'(1 << s) : 16'h0000, 0);
      end
      step(2);
      {ce, pin} = 2'b00;
      step(3);
      note(3, 16'h0003, 0);
      ce = 1'b1;
      note(3, 16'h0000, 1);
      step(2);
      RST_N = 1'b0;
      note(3, 16'h0002, 0);
      step(2);
      test_done();
   end
endmodule : clock_divider_gate_reset_sync_test
